// ===== include/frame_index_map.svh
`ifndef FRAME_INDEX_MAP_SVH
`define FRAME_INDEX_MAP_SVH

// Register byte offsets
`define OFF_CMD 8'h00
`define OFF_STAT 8'h04
`define OFF_CAP 8'h08
`define OFF_SEG 8'h0C
`define OFF_MFI 8'h2C
`define OFF_BASE 8'h34

// Command fields
`define CMD_RUN_BIT 0
`define CMD_LSIZE_LO 2
`define CMD_LSIZE_HI 3

// Status fields
`define STAT_ROLL_BIT 3
`define STAT_HALT_BIT 12

// Capability field
`define CAP_WIDE_BIT 0

// Counter and pointer layout
`define MFI_HI 13
`define MFI_RESET 14'h0000
`define SOF_LO 3
`define IDX_LO 3
`define IDX_HI 12
`define BASE_LO 12

// Reset values
`define SEG_RESET 32'h0000_0000
`define BASE_RESET 20'h0_0000
`define LSIZE_RESET 2'h0

// List size codes and the counter and index masks they select
`define LSIZE_512 2'h1
`define LSIZE_256 2'h2
`define WRAP_1024 14'h1FFF
`define WRAP_512 14'h0FFF
`define WRAP_256 14'h07FF
`define IDX_1024 10'h3FF
`define IDX_512 10'h1FF
`define IDX_256 10'h0FF

// Microframe timing
`define MICROFRAME_NS 125000
`define CLK_PERIOD_NS 50
`define TICK_CYCLES (`MICROFRAME_NS / `CLK_PERIOD_NS)

// Bus encodings
`define HSIZE_WORD 3'h2

`endif

// ===== include/frame_pkg.sv
package frame_pkg;

  // Bus state, Gray coded along idle, read wait, read done
  typedef enum logic [1:0] {
    BUS_IDLE = 2'h0,
    BUS_RWAIT = 2'h1,
    BUS_RDONE = 2'h3,
    BUS_WR = 2'h2
  } bus_state_e;

  // Captured address phase
  typedef struct packed {
    logic [7:0] addr;
    logic write;
    logic word;
  } bus_req_s;

  // Periodic list fetch request toward the memory side
  typedef struct packed {
    logic [63:0] addr;
    logic [9:0] index;
    logic [10:0] sof_frame;
  } fetch_s;

endpackage

// ===== verilog/frame_index_base.sv
`timescale 1ns/1ps
`default_nettype none
`include "frame_index_map.svh"

// Summary of operation
// (R01) Counter steps by one every 125 us microframe while running.
// (R02) Counter bits N..3 index the list; each entry serves eight microframes.
// (R03) Size 00b: 1024/N=12, 01b: 512/N=11, 10b: 256/N=10, 11b reserved.
// (R04) SOF frame number is counter bits 13..3.
// (R05) Software writes the counter only with whole 32-bit words.
// (R06) Counter register accepts writes only while halted.
// (R07) Software never writes the counter while run control is set.
// (R08) A counter write also changes the SOF frame number.
// (R09) Counter is bits 13..0, resets to zero; bits 31..14 reserved.
// (R10) Base pointer is 4 kB aligned; low address bits ignored.
// (R11) Entry address merges base with index, walking the list in order.
// (R12) With wide addressing, upper 32 address bits come from segment.
// (R13) Software loads the base pointer before starting the schedule.
// (R14) Rollover flag sets whenever the list index wraps to zero.
// (R15) Entry address is base 31..12 joined with index times four.

module frame_index_base #(
  parameter int unsigned TICK_CYCLES = `TICK_CYCLES,
  parameter logic WIDE_CAPABLE = 1'b1
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic run_control,
  output logic halted_flag,
  output logic microframe_pulse,
  output frame_pkg::fetch_s fetch
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  localparam logic [11:0] TICK_LAST = 12'(TICK_CYCLES - 1);

  frame_pkg::bus_state_e st_q;
  frame_pkg::bus_state_e st_d;
  frame_pkg::bus_req_s req_q;
  frame_pkg::fetch_s fetch_q;
  frame_pkg::fetch_s fetch_d;

  logic [31:0] hrdata_q;
  logic run_q;
  logic [1:0] lsize_q;
  logic halted_q;
  logic roll_q;
  logic roll_d;
  logic [31:0] seg_q;
  logic [19:0] base_q;
  logic [`MFI_HI:0] mfi_q;
  logic [`MFI_HI:0] mfi_d;
  logic [11:0] tick_q;
  logic pulse_q;

  ////////////////////////////////////////////////////////////////////////
  // Bus decode

  // A transfer is taken only when the bus is ready
  wire logic take = hsel & htrans[1] & hready;
  // A write data phase; the captured direction guards a stray state
  wire logic wr_en = (st_q == frame_pkg::BUS_WR) & req_q.write;
  wire logic rd_latch = (st_q == frame_pkg::BUS_RWAIT);

  // Only the low address byte is decoded, so the window repeats
  wire logic sel_cmd = (req_q.addr == `OFF_CMD);
  wire logic sel_stat = (req_q.addr == `OFF_STAT);
  wire logic sel_cap = (req_q.addr == `OFF_CAP);
  wire logic sel_seg = (req_q.addr == `OFF_SEG);
  wire logic sel_mfi = (req_q.addr == `OFF_MFI);
  wire logic sel_base = (req_q.addr == `OFF_BASE);

  // Narrow writes to the counter are dropped, never half applied, and
  // a write while the schedule runs is refused rather than racing a step
  wire logic mfi_wr =
    wr_en & sel_mfi & req_q.word & halted_q; // see (R05) (R06)

  ////////////////////////////////////////////////////////////////////////
  // Bus state machine

  // Reads take one wait state so that read data leaves a flip-flop
  always_comb begin
    st_d = frame_pkg::BUS_IDLE;
    case (st_q)
      frame_pkg::BUS_IDLE,
      frame_pkg::BUS_WR,
      frame_pkg::BUS_RDONE: begin
        if (take) begin
          st_d = hwrite ? frame_pkg::BUS_WR : frame_pkg::BUS_RWAIT;
        end
      end
      frame_pkg::BUS_RWAIT: begin
        st_d = frame_pkg::BUS_RDONE;
      end
      default: begin
        st_d = frame_pkg::BUS_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= frame_pkg::BUS_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // Address phase capture
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      req_q <= '0;
    end else if (take) begin
      req_q.addr <= haddr[7:0];
      req_q.write <= hwrite;
      req_q.word <= (hsize == `HSIZE_WORD);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read path

  // Command, status and capability words are placed bit by bit from the
  // field map, so moving a field needs only a header change
  logic [31:0] rd_cmd;
  logic [31:0] rd_stat;
  logic [31:0] rd_cap;

  // Command word: run control and list size
  always_comb begin
    rd_cmd = 32'h0000_0000;
    rd_cmd[`CMD_RUN_BIT] = run_q;
    rd_cmd[`CMD_LSIZE_HI:`CMD_LSIZE_LO] = lsize_q; // see (R03)
  end

  // Status word: halted state and the sticky rollover flag
  always_comb begin
    rd_stat = 32'h0000_0000;
    rd_stat[`STAT_HALT_BIT] = halted_q; // see (R06)
    rd_stat[`STAT_ROLL_BIT] = roll_q; // see (R14)
  end

  // Capability word: wide addressing is fixed at build time
  always_comb begin
    rd_cap = 32'h0000_0000;
    rd_cap[`CAP_WIDE_BIT] = WIDE_CAPABLE; // see (R12)
  end

  // Reserved bits and unmapped addresses read as zero
  wire logic [31:0] rd_mfi = {18'h0, mfi_q}; // see (R09)
  wire logic [31:0] rd_base = {base_q, 12'h000}; // see (R10)

  wire logic [31:0] rd_mux =
    sel_cmd ? rd_cmd :
    sel_stat ? rd_stat :
    sel_cap ? rd_cap :
    sel_seg ? seg_q :
    sel_mfi ? rd_mfi :
    sel_base ? rd_base : 32'h0000_0000;

  // Read data register
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      hrdata_q <= 32'h0000_0000;
    end else if (rd_latch) begin
      hrdata_q <= rd_mux;
    end
  end

  // Always OKAY; ready drops only for the read wait state
  assign hreadyout = (st_q != frame_pkg::BUS_RWAIT);
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  ////////////////////////////////////////////////////////////////////////
  // Command, segment and base registers

  // Command register: run control and list size
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      run_q <= 1'b0;
      lsize_q <= `LSIZE_RESET;
    end else if (wr_en & sel_cmd) begin
      run_q <= hwdata[`CMD_RUN_BIT];
      lsize_q <= hwdata[`CMD_LSIZE_HI:`CMD_LSIZE_LO];
    end
  end

  // Upper address segment
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      seg_q <= `SEG_RESET;
    end else if (wr_en & sel_seg) begin
      seg_q <= hwdata;
    end
  end

  // Only the 4 kB frame of the pointer is kept
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      base_q <= `BASE_RESET;
    end else if (wr_en & sel_base) begin
      base_q <= hwdata[31:`BASE_LO]; // see (R10)
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Halt tracking

  // Halted follows run control one cycle late, so a run start
  // always sees a settled counter before the first tick
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      halted_q <= 1'b1;
    end else begin
      halted_q <= ~run_q;
    end
  end

  assign run_control = run_q;
  assign halted_flag = halted_q;

  ////////////////////////////////////////////////////////////////////////
  // Microframe timer

  wire logic tick_end = ~halted_q & (tick_q == TICK_LAST);

  // Timer restarts on halt so the first microframe is full length; the
  // 12-bit count limits TICK_CYCLES to 4096 core clocks
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tick_q <= 12'h000;
    end else if (halted_q | tick_end) begin
      tick_q <= 12'h000;
    end else begin
      tick_q <= tick_q + 12'h001; // see (R01)
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Microframe index counter

  // List size decode; the reserved code falls back to 1024 entries so
  // a bad setting still walks the whole 4 kB list
  wire logic size_512 = (lsize_q == `LSIZE_512); // see (R03)
  wire logic size_256 = (lsize_q == `LSIZE_256); // see (R03)

  // Low counter bits that must all be one for the index to wrap
  wire logic [`MFI_HI:0] wrap_mask =
    size_512 ? `WRAP_512 :
    size_256 ? `WRAP_256 : `WRAP_1024; // see (R03)

  // Carry out of bit N means the list index returns to zero
  wire logic wrap = tick_end & ((mfi_q & wrap_mask) == wrap_mask); // see (R14)

  // Counter wraps naturally from its top value to zero
  always_comb begin
    mfi_d = mfi_q;
    if (mfi_wr) begin
      mfi_d = hwdata[`MFI_HI:0]; // see (R08)
    end else if (tick_end) begin
      mfi_d = mfi_q + 14'h0001; // see (R01) (R15)
    end
  end

  // Counter register
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mfi_q <= `MFI_RESET; // see (R09)
    end else begin
      mfi_q <= mfi_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Rollover flag

  // Write one to clear; a wrap in the same cycle wins
  wire logic roll_clr = wr_en & sel_stat & hwdata[`STAT_ROLL_BIT];

  always_comb begin
    roll_d = (roll_q & ~roll_clr) | wrap; // see (R14)
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      roll_q <= 1'b0;
    end else begin
      roll_q <= roll_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // List entry address

  // Index width shrinks with the list
  wire logic [9:0] idx_mask =
    size_512 ? `IDX_512 :
    size_256 ? `IDX_256 : `IDX_1024; // see (R03)

  wire logic [9:0] list_index =
    mfi_q[`IDX_HI:`IDX_LO] & idx_mask; // see (R02)

  // Upper half is zero unless wide addressing is present
  wire logic [31:0] upper_addr =
    WIDE_CAPABLE ? seg_q : 32'h0000_0000; // see (R12)

  // Four-byte entries within the 4 kB aligned list
  always_comb begin
    fetch_d.addr = {upper_addr, base_q, list_index, 2'h0}; // see (R11) (R15)
    fetch_d.index = list_index; // see (R02)
    fetch_d.sof_frame = mfi_q[`MFI_HI:`SOF_LO]; // see (R04) (R08)
  end

  // Fetch outputs leave flip-flops, one cycle behind the counter, while
  // the pulse marks the step itself; a consumer takes the entry one
  // cycle after the pulse
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      fetch_q <= '0;
      pulse_q <= 1'b0;
    end else begin
      fetch_q <= fetch_d;
      pulse_q <= tick_end;
    end
  end

  assign fetch = fetch_q;
  assign microframe_pulse = pulse_q;

endmodule

`default_nettype wire

// ===== dv/frame_index_base_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module frame_index_base_asserts #(
  parameter int unsigned TICK_CYCLES = 8
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic run_control,
  input wire logic halted_flag,
  input wire logic microframe_pulse,
  input wire frame_pkg::fetch_s fetch
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////
  // Cycles since the last step; a halt breaks the run, so spacing
  // is only judged between two steps of one unbroken run
  logic [15:0] gap_q;
  logic seen_q;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      gap_q <= 16'h0000;
      seen_q <= 1'b0;
    end else begin
      gap_q <= microframe_pulse ? 16'h0000 : gap_q + 16'h0001;
      seen_q <= (seen_q | microframe_pulse) & !halted_flag;
    end
  end
  ////////////////////////////////////////
  a_step_period: assert property (
    microframe_pulse && seen_q |-> gap_q == TICK_CYCLES - 1)
    else $error("step spacing wrong");
  a_step_running: assert property (
    microframe_pulse |-> !$past(halted_flag)) else $error("step while halted");
  a_sof_index: assert property (
    fetch.index[6:0] == fetch.sof_frame[6:0]) else $error("sof vs index");
  a_entry_addr: assert property (
    fetch.addr[11:0] == {fetch.index, 2'h0}) else $error("entry address");
  // The fetch port moves one cycle after the pulse or a halted write
  a_sof_steady: assert property (
    !$past(microframe_pulse) && !$past(halted_flag, 2)
      |-> $stable(fetch.sof_frame))
    else $error("sof moved off step");
  a_halt_state: assert property (
    $stable(run_control) |-> halted_flag == !run_control)
    else $error("halted flag wrong");
  a_okay_only: assert property (
    hresp == 1'b0) else $error("response not okay");
  a_one_wait: assert property (
    !hreadyout |=> hreadyout) else $error("more than one wait");
endmodule
bind frame_index_base frame_index_base_asserts #(.TICK_CYCLES(TICK_CYCLES))
  u_asserts (.core_clk, .nrst, .hreadyout, .hresp, .run_control,
  .halted_flag, .microframe_pulse, .fetch);
`default_nettype wire

// ===== dv/sys_mem.sv
`timescale 1ns/1ps
`default_nettype none
module sys_mem (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic microframe_pulse,
  input wire frame_pkg::fetch_s fetch,
  output logic hit,
  output logic [63:0] got
);
  logic pend_q;
  // The pulse comes with the step and the fetch port follows a cycle
  // later, so the entry is taken one cycle after the pulse
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pend_q <= 1'b0;
      hit <= 1'b0;
      got <= 64'h0;
    end else begin
      pend_q <= microframe_pulse;
      hit <= pend_q;
      if (pend_q) begin
        got <= fetch.addr;
      end
    end
  end
endmodule
`default_nettype wire

// ===== dv/ehci_frame_index_periodic_base_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "frame_index_map.svh"
module ehci_frame_index_periodic_base_tb;
  logic core_clk = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, run_control, halted_flag, microframe_pulse;
  logic [31:0] hrdata, base, seg;
  frame_pkg::fetch_s fetch;
  logic hit, rd_dp = 1'b0;
  logic [63:0] got;
  logic [31:0] rq[$];
  logic [63:0] fq[$];
  logic [13:0] c0, cn;
  logic [9:0] msk;
  int num_errors = 0, checks = 0, cyc = 0;
  ////////////////////////////////////////
  frame_index_base #(.TICK_CYCLES(12)) i_frame_index_base (
    .core_clk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .run_control,
    .halted_flag, .microframe_pulse, .fetch);
  sys_mem i_sys_mem (.core_clk, .nrst, .microframe_pulse, .fetch, .hit, .got);
  initial begin
    forever #25 core_clk = ~core_clk;
  end
  ////////////////////////////////////////
  task automatic end_sim();
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("Error t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Single transfer; ready is looked at mid-cycle, where it is settled
  task automatic bus(input logic [7:0] a, input logic w,
      input logic [31:0] d, input logic [2:0] s);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= s;
    do @(negedge core_clk); while (!hreadyout);
    @(posedge core_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rd_dp <= !w;
    do @(negedge core_clk); while (!hreadyout);
    @(posedge core_clk);
    rd_dp <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    bus(a, 1'b0, 32'h0, `HSIZE_WORD);
  endtask
  ////////////////////////////////////////
  // Results are matched against the oldest note as they appear
  always @(negedge core_clk) begin
    if (rd_dp && hreadyout) chk(hrdata, rq.pop_front());
    if (hit) chk(got, fq.pop_front());
  end
  // A hang counts as a mismatch and ends the run
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 2000) begin
      num_errors++;
      end_sim();
    end
  end
  ////////////////////////////////////////
  initial begin
    void'($urandom(32'hA1B20DAF));
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    rd(`OFF_MFI, 32'h0);
    rd(8'h40, 32'h0);
    base = $urandom;
    seg = $urandom;
    bus(`OFF_BASE, 1'b1, base, `HSIZE_WORD);
    bus(`OFF_SEG, 1'b1, seg, `HSIZE_WORD);
    rd(`OFF_BASE, {base[31:12], 12'h000});
    c0 = 14'($urandom);
    bus(`OFF_MFI, 1'b1, {18'h0, c0}, `HSIZE_WORD);
    bus(`OFF_MFI, 1'b1, 32'h0, 3'h0);
    rd(`OFF_MFI, {18'h0, c0});
    // Start each run one step before the list index wraps
    for (int code = 0; code < 3; code++) begin
      msk = 10'h3FF >> code;
      c0 = {1'b0, msk, 3'h7};
      bus(`OFF_MFI, 1'b1, {18'h0, c0}, `HSIZE_WORD);
      for (int k = 1; k < 4; k++) begin
        cn = 14'(c0 + k);
        fq.push_back({seg, base[31:12], cn[12:3] & msk, 2'h0});
      end
      bus(`OFF_CMD, 1'b1, {28'h0, code[1:0], 2'h1}, `HSIZE_WORD);
      rd(`OFF_STAT, 32'h0);
      while (fq.size() != 0) @(negedge core_clk);
      @(posedge core_clk);
      bus(`OFF_CMD, 1'b1, {28'h0, code[1:0], 2'h0}, `HSIZE_WORD);
      rd(`OFF_MFI, {18'h0, 14'(c0 + 3)});
      rd(`OFF_STAT, 32'h1008);
      bus(`OFF_STAT, 1'b1, 32'h8, `HSIZE_WORD);
      rd(`OFF_STAT, 32'h1000);
      rd(`OFF_CMD, {28'h0, code[1:0], 2'h0});
    end
    end_sim();
  end
endmodule
`default_nettype wire
